/* core/spo_regs.svh */
// constants for the serial flash power-on state block
// Overview of operation
// [R1] data out undriven until an instruction runs
// [R2] instruction starts only after a select fall
// [R3] select fall samples clock idle: high mode3
// [R4] commands ignored while power-on hold is active
// [R5] host waits 70 us before first read
// [R6] host waits 3 ms before program/erase
// [R7] after delay: standby if select high, else active
// [R8] power-good input starts waits, loss forces hold
`ifndef SPO_REGS_SVH
`define SPO_REGS_SVH
`define SPO_CLK_MHZ 100
`define SPO_READ_WAIT_US 70
`define SPO_WRITE_WAIT_MS 3
`define SPO_READ_WAIT_CYC (`SPO_READ_WAIT_US * `SPO_CLK_MHZ)
`define SPO_WRITE_WAIT_CYC (`SPO_WRITE_WAIT_MS * 1000 * `SPO_CLK_MHZ)
`define SPO_CNT_W 20
`endif

/* core/spo_pkg.sv */
// types for the serial flash power-on state block
package spo_pkg;
  typedef enum logic [1:0] {
    SPO_HOLD,
    SPO_WAIT,
    SPO_STANDBY,
    SPO_ACTIVE
  } spo_state_e;
  typedef logic [19:0] spo_cnt_t;
endpackage

/* core/spo_sync.sv */
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module spo_sync (
  input  wire logic clk_i,     // block clock
  input  wire logic reset_n_i, // async reset, active low
  input  wire logic d_i,       // asynchronous level
  output logic      q_o        // synchronised level
);
  logic meta_q;
  logic meta_d;
  logic q_d;
  // next values: first stage read only by the second
  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end
  // register both stages
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= meta_d;
      q_o    <= q_d;
    end
  end
endmodule

/* core/spo_power_state.sv */
// power-on state and spi entry logic of the serial flash port
`timescale 1ns/1ps
`include "spo_regs.svh"
module spo_power_state
  import spo_pkg::*;
#(
  parameter int unsigned READ_WAIT_CYC  = `SPO_READ_WAIT_CYC,
  parameter int unsigned WRITE_WAIT_CYC = `SPO_WRITE_WAIT_CYC
) (
  input  wire logic clk_i,            // 100 MHz clock
  input  wire logic reset_n_i,        // async reset, active low
  input  wire logic power_good_i,     // supply valid level (pin)
  input  wire logic select_bar_i,     // chip select, active low (pin)
  input  wire logic sck_i,            // serial clock (pin)
  input  wire logic so_data_i,        // data from core for output
  input  wire logic instr_busy_i,     // core reports instruction running
  output logic      so_o,             // serial data out value
  output logic      so_oe_o,          // serial data out enable
  output logic      mode3_o,          // 1: mode 3, 0: mode 0
  output logic      instr_start_o,    // pulse: instruction may begin
  output logic      in_frame_o,       // accepted frame in progress
  output logic      hold_o,           // power-on hold active
  output logic      read_ok_o,        // read wait elapsed
  output logic      write_ok_o,       // program/erase wait elapsed
  output logic      standby_o,        // standby state
  output logic      active_o          // active state
);
  logic pg_s;
  logic sel_s;
  logic sck_s;
  // synchronise pins
  spo_sync u_pg (.clk_i(clk_i), .reset_n_i(reset_n_i),
                 .d_i(power_good_i), .q_o(pg_s));
  spo_sync u_sel (.clk_i(clk_i), .reset_n_i(reset_n_i),
                  .d_i(select_bar_i), .q_o(sel_s));
  spo_sync u_sck (.clk_i(clk_i), .reset_n_i(reset_n_i),
                  .d_i(sck_i), .q_o(sck_s));

  spo_state_e state_q, state_d;
  spo_cnt_t   cnt_q, cnt_d;
  logic       sel_prev_q, sel_prev_d;
  logic       hold_d, stby_d, act_d;
  logic       armed_q, armed_d;
  logic       mode3_d, start_d, frame_d, so_d, oe_d;
  logic       rok_d, wok_d;
  logic       sel_fall;

  assign sel_fall = sel_prev_q & ~sel_s;

  // state, counter and frame tracking
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    sel_prev_d = sel_s;
    armed_d    = armed_q;
    mode3_d    = mode3_o;
    start_d    = 1'b0;
    frame_d    = in_frame_o;
    rok_d      = read_ok_o;
    wok_d      = write_ok_o;
    if (!pg_s) begin
      state_d = SPO_HOLD;                             // [R8]
      cnt_d   = '0;
      armed_d = 1'b0;
      frame_d = 1'b0;
      rok_d   = 1'b0;
      wok_d   = 1'b0;
    end else begin
      unique case (state_q)
        SPO_HOLD: begin
          state_d = SPO_WAIT;                         // [R8]
          cnt_d   = '0;
        end
        SPO_WAIT: begin
          cnt_d = cnt_q + 20'h00001;
          if (32'(cnt_q) + 1 >= READ_WAIT_CYC)
            rok_d = 1'b1;                             // [R5]
          if (32'(cnt_q) + 1 >= WRITE_WAIT_CYC) begin
            wok_d   = 1'b1;                           // [R6]
            state_d = sel_s ? SPO_STANDBY : SPO_ACTIVE; // [R7]
          end
        end
        SPO_STANDBY: if (!sel_s) state_d = SPO_ACTIVE; // [R7]
        SPO_ACTIVE:  if (sel_s) state_d = SPO_STANDBY; // [R7]
      endcase
      // a frame needs select high seen first, then a fall
      if (sel_s) begin
        armed_d = 1'b1;                               // [R2]
        frame_d = 1'b0;
      end
      if (sel_fall && armed_q && state_q != SPO_HOLD) begin // [R4]
        mode3_d = sck_s;                              // [R3]
        start_d = 1'b1;                               // [R2]
        frame_d = 1'b1;
      end
    end
    so_d = so_data_i;
    oe_d = frame_d & instr_busy_i & ~sel_s;           // [R1]
    if (state_q == SPO_HOLD)
      oe_d = 1'b0;                                    // [R4]
    hold_d = (state_d == SPO_HOLD);                   // [R8]
    stby_d = (state_d == SPO_STANDBY);                // [R7]
    act_d  = (state_d == SPO_ACTIVE);                 // [R7]
  end

  // register everything; all outputs come from flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q       <= SPO_HOLD;
      cnt_q         <= '0;
      sel_prev_q    <= 1'b0;
      armed_q       <= 1'b0;
      mode3_o       <= 1'b0;
      instr_start_o <= 1'b0;
      in_frame_o    <= 1'b0;
      so_o          <= 1'b0;
      so_oe_o       <= 1'b0;
      read_ok_o     <= 1'b0;
      write_ok_o    <= 1'b0;
      hold_o        <= 1'b1;
      standby_o     <= 1'b0;
      active_o      <= 1'b0;
    end else begin
      state_q       <= state_d;
      cnt_q         <= cnt_d;
      sel_prev_q    <= sel_prev_d;
      armed_q       <= armed_d;
      mode3_o       <= mode3_d;
      instr_start_o <= start_d;
      in_frame_o    <= frame_d;
      so_o          <= so_d;
      so_oe_o       <= oe_d;
      read_ok_o     <= rok_d;
      write_ok_o    <= wok_d;
      hold_o        <= hold_d;
      standby_o     <= stby_d;
      active_o      <= act_d;
    end
  end

  // frame entry steps: an accepted select fall, then start and frame flag
  sequence fall_taken_s;
    sel_fall && armed_q && pg_s && (state_q != SPO_HOLD);
  endsequence
  sequence frame_opened_s;
    instr_start_o && in_frame_o;
  endsequence

  // no drive outside a frame, without a running instruction or deselected
  undriven_idle_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (!reset_n_i)
    !in_frame_o |-> !so_oe_o)
    else $error("output driven outside frame");
  drive_needs_busy_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (!reset_n_i)
    so_oe_o |-> $past(instr_busy_i))
    else $error("output driven without instruction");
  deselect_release_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (!reset_n_i)
    sel_s |=> !so_oe_o)
    else $error("output driven after deselect");
  // a start pulse follows each accepted fall and nothing else
  fall_starts_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (!reset_n_i)
    fall_taken_s |=> frame_opened_s)
    else $error("accepted fall gave no start");
  start_needs_fall_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (!reset_n_i)
    instr_start_o |-> $past(sel_fall))
    else $error("start without fall");
  start_single_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (!reset_n_i)
    instr_start_o |=> !instr_start_o)
    else $error("start pulse longer than one cycle");
  unarmed_refused_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (!reset_n_i)
    sel_fall && !armed_q |=> !instr_start_o)
    else $error("start on unarmed fall");
  // mode taken from the idle clock at the fall and held otherwise
  mode_sample_a: assert property ( // [R3]
    @(posedge clk_i) disable iff (!reset_n_i)
    instr_start_o |-> mode3_o == $past(sck_s))
    else $error("bad mode");
  mode_steady_a: assert property ( // [R3]
    @(posedge clk_i) disable iff (!reset_n_i)
    $changed(mode3_o) |-> instr_start_o)
    else $error("mode changed without a fall");
  // hold keeps the port quiet and clears all progress
  hold_quiet_a: assert property ( // [R4]
    @(posedge clk_i) disable iff (!reset_n_i)
    hold_o |-> !instr_start_o && !so_oe_o)
    else $error("cmd in hold");
  hold_clear_a: assert property ( // [R4]
    @(posedge clk_i) disable iff (!reset_n_i)
    hold_o |-> !read_ok_o && !write_ok_o && !in_frame_o)
    else $error("progress kept in hold");
  // read wait ends after exactly its count
  read_order_a: assert property ( // [R5]
    @(posedge clk_i) disable iff (!reset_n_i)
    write_ok_o |-> read_ok_o)
    else $error("write ok before read ok");
  read_count_a: assert property ( // [R5]
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(read_ok_o) |-> cnt_q == spo_cnt_t'(READ_WAIT_CYC))
    else $error("read wait count wrong");
  // program/erase wait ends after exactly its count
  write_gate_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (!reset_n_i)
    (standby_o || active_o) |-> write_ok_o)
    else $error("early ready");
  write_count_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(write_ok_o) |-> cnt_q == spo_cnt_t'(WRITE_WAIT_CYC))
    else $error("write wait count wrong");
  // ready state follows the select level while power stays good
  state_sel_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (!reset_n_i)
    standby_o && !sel_s && pg_s |=> active_o)
    else $error("no active");
  active_sel_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (!reset_n_i)
    active_o && sel_s && pg_s |=> standby_o)
    else $error("no standby");
  // power-good loss forces hold, good power keeps the flags
  pg_loss_a: assert property ( // [R8]
    @(posedge clk_i) disable iff (!reset_n_i)
    !pg_s |=> hold_o && !read_ok_o)
    else $error("no hold on loss");
  ok_keep_a: assert property ( // [R8]
    @(posedge clk_i) disable iff (!reset_n_i)
    read_ok_o && pg_s |=> read_ok_o)
    else $error("read ok lost with power good");
endmodule

/* verification/spo_host_model.sv */
// spi host model driving select and serial clock
`timescale 1ns/1ps
module spo_host_model (
  input  wire logic clk_i,        // block clock for pacing
  output logic      select_bar_o, // chip select, active low
  output logic      sck_o         // serial clock, 80 ns period
);
  // idle: deselected, clock standing still
  initial begin
    select_bar_o = 1'b1;
    sck_o        = 1'b0;
  end
  // set idle clock level, drop select, run four clock edges
  task automatic open_frame(input logic idle);
    @(posedge clk_i) #1 sck_o = idle;
    repeat (4) @(posedge clk_i);
    #1 select_bar_o = 1'b0;
    repeat (4) begin
      repeat (4) @(posedge clk_i);
      #1 sck_o = ~sck_o;
    end
  endtask
  // clock is back at idle, so just deselect
  task automatic close_frame();
    repeat (4) @(posedge clk_i);
    #1 select_bar_o = 1'b1;
  endtask
endmodule

/* verification/spo_power_state_test.sv */
// self-checking bench for the power-on state block
`timescale 1ns/1ps
module spo_power_state_test;
  logic clk_i, reset_n_i, power_good_i, so_data_i, instr_busy_i;
  logic select_bar, sck, so_o, so_oe_o, mode3_o, instr_start_o;
  logic in_frame_o, hold_o, read_ok_o, write_ok_o, standby_o, active_o;
  int   n_mismatch, checks, n_start, cyc;
  spo_power_state #(.READ_WAIT_CYC(20), .WRITE_WAIT_CYC(50)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .power_good_i(power_good_i),
    .select_bar_i(select_bar), .sck_i(sck), .so_data_i(so_data_i),
    .instr_busy_i(instr_busy_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .mode3_o(mode3_o), .instr_start_o(instr_start_o),
    .in_frame_o(in_frame_o), .hold_o(hold_o), .read_ok_o(read_ok_o),
    .write_ok_o(write_ok_o), .standby_o(standby_o), .active_o(active_o));
  spo_host_model host_u (.clk_i(clk_i), .select_bar_o(select_bar),
    .sck_o(sck));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // start pulse counter and hang limit
  always @(posedge clk_i) begin
    cyc++;
    if (instr_start_o === 1'b1) n_start++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // a frame before power good is ignored
  task automatic t_hold();
    int n0 = n_start;
    instr_busy_i = 1'b1;
    host_u.open_frame(1'b0);
    chk("start in hold", 1'b1, n_start == n0);
    chk("frame in hold", 1'b0, in_frame_o);
    chk("so_oe in hold", 1'b0, so_oe_o);
    chk("hold", 1'b1, hold_o);
    instr_busy_i = 1'b0;
    host_u.close_frame();
    $display("test hold done");
  endtask
  // both waits counted from power good
  task automatic t_waits();
    int k = 0;
    power_good_i = 1'b1;
    while (read_ok_o !== 1'b1 && k < 300) begin step(1); k++; end
    chk("read wait", 1'b1, k >= 20);
    chk("write early", 1'b0, write_ok_o);
    while (write_ok_o !== 1'b1 && k < 300) begin step(1); k++; end
    chk("write wait", 1'b1, k >= 50 && k < 60);
    step(2);
    chk("standby", 1'b1, standby_o);
    chk("active", 1'b0, active_o);
    $display("test waits done");
  endtask
  // frame with given idle clock; host waited for write_ok
  task automatic t_mode(input logic idle);
    int n0 = n_start;
    host_u.open_frame(idle);
    chk("mode3", idle, mode3_o);
    chk("one start", 1'b1, n_start == n0 + 1);
    chk("active", 1'b1, active_o);
    instr_busy_i = 1'b1;
    so_data_i = ~idle;
    step(2);
    chk("so_oe busy", 1'b1, so_oe_o);
    chk("so", ~idle, so_o);
    instr_busy_i = 1'b0;
    host_u.close_frame();
    step(6);
    chk("so_oe idle", 1'b0, so_oe_o);
    chk("standby", 1'b1, standby_o);
    $display("test mode done");
  endtask
  // loss of power good forces hold
  task automatic t_loss();
    power_good_i = 1'b0;
    step(6);
    chk("hold", 1'b1, hold_o);
    chk("read_ok", 1'b0, read_ok_o);
    chk("write_ok", 1'b0, write_ok_o);
    chk("standby off", 1'b0, standby_o);
    chk("active off", 1'b0, active_o);
    $display("test loss done");
  endtask
  // select held low through power-up: active, but no start
  task automatic t_low_sel();
    int n0 = n_start;
    host_u.open_frame(1'b0);
    power_good_i = 1'b1;
    step(60);
    chk("write ok low sel", 1'b1, write_ok_o);
    chk("active low sel", 1'b1, active_o);
    chk("no start unarmed", 1'b1, n_start == n0);
    host_u.close_frame();
    step(4);
    chk("standby after", 1'b1, standby_o);
    $display("test low select done");
  endtask
  // main sequence
  initial begin
    {reset_n_i, power_good_i, so_data_i, instr_busy_i} = 4'h0;
    step(12);
    chk("hold in reset", 1'b1, hold_o);
    chk("so_oe in reset", 1'b0, so_oe_o);
    reset_n_i = 1'b1;
    step(4);
    t_hold();
    t_waits();
    t_mode(1'b0);
    t_mode(1'b1);
    t_loss();
    t_low_sel();
    wrap_up();
  end
endmodule
